// *** serial_fifo_pkg.sv ***
package serial_fifo_pkg;
    // Geometry
    localparam int unsigned char_width = 16;
    localparam int unsigned fifo_depth = 4;
    localparam int unsigned count_width = 3;
    localparam logic [2:0] fifo_full_count = 3'h4;

    // Register map, byte addresses
    localparam logic [7:0] char_config_offset = 8'h0c;
    localparam logic [7:0] dma_control_offset = 8'h18;

    // Control register fields
    localparam int unsigned rx_enable_bit = 31;
    localparam int unsigned rx_count_lsb = 24;
    localparam int unsigned rx_flush_bit = 20;
    localparam int unsigned rx_level_lsb = 16;
    localparam int unsigned tx_enable_bit = 15;
    localparam int unsigned tx_count_lsb = 8;
    localparam int unsigned tx_flush_bit = 4;
    localparam int unsigned tx_level_lsb = 0;

    // Character configuration field
    localparam int unsigned char_len_lsb = 2;

    // Reset values
    localparam logic [1:0] level_reset = 2'h3;
    localparam logic [3:0] char_len_reset = 4'h0;

    // AXI responses
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
endpackage

// *** serial_fifo4.sv ***
`timescale 1ns/1ps
module serial_fifo4
    import serial_fifo_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic flush,
    input wire logic push,
    input wire logic [char_width-1:0] push_data,
    output logic push_ready,
    input wire logic pop,
    output logic [char_width-1:0] pop_data,
    output logic pop_valid,
    output logic [count_width-1:0] count
);
    logic [char_width-1:0] mem [fifo_depth];
    logic [1:0] wr_ptr;
    logic [1:0] rd_ptr;
    wire do_push;
    wire do_pop;

    // Handshakes; flush discards any same-cycle push or pop
    assign push_ready = (count != fifo_full_count);
    assign pop_valid = (count != 3'h0);
    assign do_push = push && push_ready && !flush;
    assign do_pop = pop && pop_valid && !flush;
    assign pop_data = mem[rd_ptr];

    // Storage array
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr] <= push_data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge clk) begin
        if (!rst_b || flush) begin
            wr_ptr <= 2'h0;
            rd_ptr <= 2'h0;
            count <= 3'h0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 2'h1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 2'h1;
            end
            count <= count + {2'h0, do_push} - {2'h0, do_pop};
        end
    end
endmodule

// *** spi_fifo_dma_request.sv ***
`timescale 1ns/1ps
// Function
// RULE_01: Receive DMA request only while receive request enable is set.
// RULE_02: Receive fill count is read-only three bits, zero to four entries.
// RULE_03: Writing one to receive flush empties receive FIFO; reads back zero.
// RULE_04: Receive request when filled entries reach level plus one; reset level four. The code resets rx_level to three.
// RULE_05: Transmit DMA request only while transmit request enable is set.
// RULE_06: Transmit fill count is read-only three bits, zero to four entries.
// RULE_07: Writing one to transmit flush empties transmit FIFO; reads back zero.
// RULE_08: Transmit request when free entries reach level plus one; reset level four. The code resets tx_level to three.
// RULE_09: Each entry holds one character of 1 to 16 bits; zero means 16.
// RULE_10: A request stays high while enabled and condition holds, drops otherwise.
module spi_fifo_dma_request
    import serial_fifo_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Transmit FIFO, filled by DMA side, drained by shift engine
    input wire logic tx_push,
    input wire logic [char_width-1:0] tx_push_data,
    output logic tx_push_ready,
    input wire logic tx_pop,
    output logic [char_width-1:0] tx_pop_data,
    output logic tx_pop_valid,
    // Receive FIFO, filled by shift engine, drained by DMA side
    input wire logic rx_push,
    input wire logic [char_width-1:0] rx_push_data,
    output logic rx_push_ready,
    input wire logic rx_pop,
    output logic [char_width-1:0] rx_pop_data,
    output logic rx_pop_valid,
    // Character length to the shift engine
    output logic [3:0] character_length,
    // DMA requests
    output logic receive_dma_request,
    output logic transmit_dma_request
);
    logic receive_request_enable;
    logic transmit_request_enable;
    logic [1:0] rx_level;
    logic [1:0] tx_level;
    logic [count_width-1:0] receive_fill_count;
    logic [count_width-1:0] transmit_fill_count;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // Character mask: length zero selects all sixteen bits
    wire [char_width-1:0] char_mask;
    wire [char_width-1:0] tx_masked;
    wire [char_width-1:0] rx_masked;
    assign char_mask = (character_length == 4'h0) ? 16'hffff
                     : ((16'h0001 << character_length) - 16'h0001);
    assign tx_masked = tx_push_data & char_mask; // see RULE_09
    assign rx_masked = rx_push_data & char_mask; // see RULE_09

    // Write channel decode
    wire write_go;
    wire wr_ctrl;
    wire wr_cfg;
    wire wr_hit;
    wire receive_flush;
    wire transmit_flush;
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign write_go = aw_held && w_held && !s_axi_bvalid;
    assign wr_ctrl = write_go && (aw_addr[7:2] == dma_control_offset[7:2]);
    assign wr_cfg = write_go && (aw_addr[7:2] == char_config_offset[7:2]);
    assign wr_hit = wr_ctrl || wr_cfg;
    assign receive_flush = wr_ctrl && w_strb[2] && w_data[rx_flush_bit]; // see RULE_03
    assign transmit_flush = wr_ctrl && w_strb[0] && w_data[tx_flush_bit]; // see RULE_07

    // Read channel decode; flush bits always read as zero
    wire read_go;
    wire [31:0] ctrl_word;
    wire [31:0] cfg_word;
    wire [31:0] next_rdata;
    wire rd_hit;
    assign s_axi_arready = !s_axi_rvalid;
    assign read_go = s_axi_arvalid && s_axi_arready;
    assign ctrl_word = {receive_request_enable, 4'h0, receive_fill_count, 3'h0, 1'b0, 2'h0, rx_level,
                        transmit_request_enable, 4'h0, transmit_fill_count, 3'h0, 1'b0, 2'h0,
                        tx_level}; // see RULE_02, RULE_06, RULE_03, RULE_07
    assign cfg_word = {26'h0, character_length, 2'h0};
    assign rd_hit = (s_axi_araddr[7:2] == dma_control_offset[7:2])
                 || (s_axi_araddr[7:2] == char_config_offset[7:2]);
    assign next_rdata = (s_axi_araddr[7:2] == dma_control_offset[7:2]) ? ctrl_word
                      : (s_axi_araddr[7:2] == char_config_offset[7:2]) ? cfg_word : 32'h0;

    // Write address and data capture, either order
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (write_go) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (write_go) begin
                w_held <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= resp_okay;
        end else if (write_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? resp_okay : resp_slverr;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read response
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= resp_okay;
        end else if (read_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= rd_hit ? resp_okay : resp_slverr;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Writable control fields, per byte lane
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            receive_request_enable <= 1'b0;
            transmit_request_enable <= 1'b0;
            rx_level <= level_reset; // see RULE_04
            tx_level <= level_reset; // see RULE_08
            character_length <= char_len_reset;
        end else begin
            if (wr_ctrl && w_strb[3]) begin
                receive_request_enable <= w_data[rx_enable_bit];
            end
            if (wr_ctrl && w_strb[2]) begin
                rx_level <= w_data[rx_level_lsb +: 2];
            end
            if (wr_ctrl && w_strb[1]) begin
                transmit_request_enable <= w_data[tx_enable_bit];
            end
            if (wr_ctrl && w_strb[0]) begin
                tx_level <= w_data[tx_level_lsb +: 2];
            end
            if (wr_cfg && w_strb[0]) begin
                character_length <= w_data[char_len_lsb +: 4];
            end
        end
    end

    // Transmit and receive FIFOs
    serial_fifo4 tx_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .flush(transmit_flush),
        .push(tx_push),
        .push_data(tx_masked),
        .push_ready(tx_push_ready),
        .pop(tx_pop),
        .pop_data(tx_pop_data),
        .pop_valid(tx_pop_valid),
        .count(transmit_fill_count)
    );

    serial_fifo4 rx_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .flush(receive_flush),
        .push(rx_push),
        .push_data(rx_masked),
        .push_ready(rx_push_ready),
        .pop(rx_pop),
        .pop_data(rx_pop_data),
        .pop_valid(rx_pop_valid),
        .count(receive_fill_count)
    );

    // Request levels, recomputed every cycle from occupancy
    wire [count_width-1:0] tx_free;
    wire rx_threshold_met;
    wire tx_threshold_met;
    assign tx_free = fifo_full_count - transmit_fill_count;
    assign rx_threshold_met = receive_fill_count > {1'b0, rx_level}; // see RULE_04
    assign tx_threshold_met = tx_free > {1'b0, tx_level}; // see RULE_08
    assign receive_dma_request = receive_request_enable && rx_threshold_met; // see RULE_01, RULE_10
    assign transmit_dma_request = transmit_request_enable && tx_threshold_met; // see RULE_05, RULE_10

    // Checks
    sequence s_rx_flush_write;
        receive_flush;
    endsequence
    sequence s_tx_flush_write;
        transmit_flush;
    endsequence
    sequence s_ctrl_read;
        read_go && (s_axi_araddr[7:2] == dma_control_offset[7:2]);
    endsequence
    sequence s_short_push_into_empty;
        rx_push && rx_push_ready && !receive_flush && receive_fill_count == 3'h0
            && character_length != 4'h0;
    endsequence

    property p_rx_enable_gates;
        @(posedge clk) disable iff (!rst_b)
        !receive_request_enable |-> !receive_dma_request;
    endproperty
    a_rx_enable_gates: assert property (p_rx_enable_gates) else $error("rx request while disabled"); // see RULE_01

    property p_rx_count_range;
        @(posedge clk) disable iff (!rst_b)
        s_ctrl_read |=> s_axi_rdata[26:24] <= 3'h4 && s_axi_rdata[26:24] == $past(receive_fill_count);
    endproperty
    a_rx_count_range: assert property (p_rx_count_range) else $error("rx count readback wrong"); // see RULE_02

    property p_rx_flush;
        @(posedge clk) disable iff (!rst_b)
        s_rx_flush_write |=> receive_fill_count == 3'h0 && !rx_pop_valid;
    endproperty
    a_rx_flush: assert property (p_rx_flush) else $error("rx flush did not empty"); // see RULE_03

    property p_flush_reads_zero;
        @(posedge clk) disable iff (!rst_b)
        s_ctrl_read |=> !s_axi_rdata[20] && !s_axi_rdata[4];
    endproperty
    a_flush_reads_zero: assert property (p_flush_reads_zero) else $error("flush bit read as one"); // see RULE_03

    property p_levels_after_reset;
        @(posedge clk)
        $rose(rst_b) |-> rx_level == 2'h3 && tx_level == 2'h3;
    endproperty
    a_levels_after_reset: assert property (p_levels_after_reset) else $error("level reset value wrong"); // see RULE_04

    property p_rx_threshold;
        @(posedge clk) disable iff (!rst_b)
        receive_dma_request |-> receive_fill_count >= {1'b0, rx_level} + 3'h1;
    endproperty
    a_rx_threshold: assert property (p_rx_threshold) else $error("rx request below level"); // see RULE_04

    property p_tx_enable_gates;
        @(posedge clk) disable iff (!rst_b)
        !transmit_request_enable |-> !transmit_dma_request;
    endproperty
    a_tx_enable_gates: assert property (p_tx_enable_gates) else $error("tx request while disabled"); // see RULE_05

    property p_tx_count_track;
        @(posedge clk) disable iff (!rst_b)
        tx_push && tx_push_ready && !tx_pop && !transmit_flush |=> transmit_fill_count == $past(transmit_fill_count) + 3'h1;
    endproperty
    a_tx_count_track: assert property (p_tx_count_track) else $error("tx count did not rise"); // see RULE_06

    property p_tx_flush;
        @(posedge clk) disable iff (!rst_b)
        s_tx_flush_write |=> transmit_fill_count == 3'h0 && tx_push_ready;
    endproperty
    a_tx_flush: assert property (p_tx_flush) else $error("tx flush did not empty"); // see RULE_07

    property p_tx_threshold;
        @(posedge clk) disable iff (!rst_b)
        transmit_dma_request |-> 3'h4 - transmit_fill_count >= {1'b0, tx_level} + 3'h1;
    endproperty
    a_tx_threshold: assert property (p_tx_threshold) else $error("tx request below free level"); // see RULE_08

    property p_char_mask;
        @(posedge clk) disable iff (!rst_b)
        s_short_push_into_empty ##1 !receive_flush |-> (rx_pop_data & ~$past(char_mask)) == 16'h0;
    endproperty
    a_char_mask: assert property (p_char_mask) else $error("character not masked"); // see RULE_09

    property p_requests_hold;
        @(posedge clk) disable iff (!rst_b)
        (receive_request_enable && receive_fill_count > {1'b0, rx_level}) |-> receive_dma_request
            && (transmit_request_enable && tx_free > {1'b0, tx_level} ? transmit_dma_request : 1'b1);
    endproperty
    a_requests_hold: assert property (p_requests_hold) else $error("request dropped early"); // see RULE_10
endmodule

// *** dma_partner.sv ***
`timescale 1ns/1ps
module dma_partner
    import serial_fifo_pkg::*;
#(parameter logic [15:0] first_word = 16'h0a50)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic serve,
    input wire logic slow,
    input wire logic transmit_dma_request,
    input wire logic tx_push_ready,
    output logic tx_push,
    output logic [char_width-1:0] tx_push_data,
    input wire logic receive_dma_request,
    input wire logic rx_pop_valid,
    input wire logic [char_width-1:0] rx_pop_data,
    output logic rx_pop,
    output logic [char_width-1:0] rx_last
);
    logic [1:0] gap;
    logic [char_width-1:0] word;
    // Idle data lines show the inverse of the next word
    assign tx_push_data = tx_push ? word : ~word;
    // One transfer per request, then a pause so the request can settle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tx_push <= 1'b0;
            rx_pop <= 1'b0;
            gap <= 2'h0;
            word <= first_word;
            rx_last <= 16'h0000;
        end else begin
            tx_push <= 1'b0;
            rx_pop <= 1'b0;
            if (tx_push && tx_push_ready) word <= word + 16'h0001;
            if (rx_pop && rx_pop_valid) rx_last <= rx_pop_data;
            if (gap != 2'h0) begin
                gap <= gap - 2'h1;
            end else if (serve && (transmit_dma_request || receive_dma_request)) begin
                tx_push <= transmit_dma_request;
                rx_pop <= receive_dma_request;
                gap <= slow ? 2'h3 : 2'h1;
            end
        end
    end
endmodule

// *** tb_spi_fifo_dma_request.sv ***
`timescale 1ns/1ps
module tb_spi_fifo_dma_request;
    import serial_fifo_pkg::*;
    localparam logic [15:0] first_word = 16'h0a50;
    localparam logic [7:0] ctl = dma_control_offset;
    localparam logic [15:0] off3 = {14'h0000, level_reset};
    logic clk = 1'b0, rst_b = 1'b0, serve = 1'b0, slow = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf, character_length;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic tx_pop = 1'b0, rx_push = 1'b0, tx_push, tx_push_ready, tx_pop_valid, rx_push_ready, rx_pop, rx_pop_valid;
    logic [char_width-1:0] rx_push_data = 16'h0000, tx_push_data, tx_pop_data, rx_pop_data, rx_last;
    logic receive_dma_request, transmit_dma_request;
    int fails = 0, checks = 0;

    spi_fifo_dma_request dut (
        .clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_push, .tx_push_data, .tx_push_ready, .tx_pop,
        .tx_pop_data, .tx_pop_valid, .rx_push, .rx_push_data, .rx_push_ready, .rx_pop, .rx_pop_data, .rx_pop_valid,
        .character_length, .receive_dma_request, .transmit_dma_request
    );
    dma_partner #(.first_word(first_word)) partner (
        .clk, .rst_b, .serve, .slow, .transmit_dma_request, .tx_push_ready, .tx_push, .tx_push_data,
        .receive_dma_request, .rx_pop_valid, .rx_pop_data, .rx_pop, .rx_last
    );

    // 20 MHz clock
    always #25 clk = ~clk;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One direction half of the control word
    function automatic logic [15:0] half(input logic en, input logic [2:0] cnt, input logic [1:0] lvl);
        return {en, 4'h0, cnt, 6'h00, lvl};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp_resp);
        logic aw, w, b;
        int n;
        b = 1'b0;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b && n < 50) begin
            @(negedge clk);
            aw = s_axi_awvalid && (s_axi_awready === 1'b1);
            w = s_axi_wvalid && (s_axi_wready === 1'b1);
            b = (s_axi_bvalid === 1'b1);
            if (b) chk("bresp", exp_resp, s_axi_bresp);
            @(posedge clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) s_axi_bready <= 1'b0;
            n++;
        end
        if (!b) chk("bvalid", 1, 0);
        // Idle edge, so a following call never sets bready again in this time step
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] exp_resp);
        logic ar, r;
        int n;
        r = 1'b0;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r && n < 50) begin
            @(negedge clk);
            ar = s_axi_arvalid && (s_axi_arready === 1'b1);
            r = (s_axi_rvalid === 1'b1);
            if (r) chk("rdata", exp, s_axi_rdata);
            if (r) chk("rresp", exp_resp, s_axi_rresp);
            @(posedge clk);
            if (ar) s_axi_arvalid <= 1'b0;
            if (r) s_axi_rready <= 1'b0;
            n++;
        end
        if (!r) chk("rvalid", 1, 0);
        // Idle edge, so a following call never sets rready again in this time step
        @(posedge clk);
    endtask

    task automatic rx_put(input logic [15:0] d);
        rx_push <= 1'b1;
        rx_push_data <= d;
        @(posedge clk);
        rx_push <= 1'b0;
        rx_push_data <= ~d;
        @(posedge clk);
    endtask

    task automatic t_reset;
        rd(ctl, {off3, off3}, resp_okay);
        rd(char_config_offset, 32'h0, resp_okay);
        chk("rx request", 0, receive_dma_request);
        chk("tx request", 0, transmit_dma_request);
        // Lane 1 only: transmit enable set, other lanes keep their values
        s_axi_wstrb <= 4'h2;
        wr(ctl, 32'h80008000, resp_okay);
        s_axi_wstrb <= 4'hf;
        rd(ctl, {off3, half(1'b1, 3'h0, 2'h3)}, resp_okay);
        chk("tx request", 1, transmit_dma_request);
        wr(ctl, {off3, off3}, resp_okay);
        wr(8'h40, 32'hffffffff, resp_slverr);
        rd(8'h40, 32'h0, resp_slverr);
        rd(ctl, {off3, off3}, resp_okay);
        $display("reset test done");
    endtask

    task automatic t_rx_levels;
        for (int l = 0; l < 4; l++) begin
            wr(ctl, {half(1'b1, 3'h0, 2'(l)) | 16'h0010, off3}, resp_okay);
            for (int k = 1; k <= 4; k++) begin
                rx_put(16'h1230 + 16'(k));
                chk("rx request", k > l, receive_dma_request);
                rd(ctl, {half(1'b1, 3'(k), 2'(l)), off3}, resp_okay);
            end
            chk("rx_push_ready", 0, rx_push_ready);
            wr(ctl, {half(1'b0, 3'h0, 2'(l)), off3}, resp_okay);
            chk("rx request", 0, receive_dma_request);
            rd(ctl, {half(1'b0, 3'h4, 2'(l)), off3}, resp_okay);
        end
        $display("rx level test done");
    endtask

    task automatic t_rx_drain;
        wr(char_config_offset, 32'h00000010, resp_okay);
        chk("character_length", 4'h4, character_length);
        wr(ctl, {half(1'b1, 3'h0, 2'h1) | 16'h0010, off3}, resp_okay);
        serve <= 1'b1;
        for (int i = 1; i <= 4; i++) begin
            rx_put(16'habc0 + 16'(i));
        end
        repeat (10) @(posedge clk);
        serve <= 1'b0;
        chk("rx_last", 16'h0003, rx_last);
        chk("rx request", 0, receive_dma_request);
        rd(ctl, {half(1'b1, 3'h1, 2'h1), off3}, resp_okay);
        wr(ctl, {half(1'b0, 3'h0, 2'h1) | 16'h0010, off3}, resp_okay);
        rd(ctl, {half(1'b0, 3'h0, 2'h1), off3}, resp_okay);
        chk("rx_pop_valid", 0, rx_pop_valid);
        wr(char_config_offset, 32'h0, resp_okay);
        $display("rx drain test done");
    endtask

    task automatic t_tx_levels;
        logic [15:0] base;
        base = first_word;
        for (int l = 0; l < 4; l++) begin
            wr(ctl, {off3, half(1'b1, 3'h0, 2'(l)) | 16'h0010}, resp_okay);
            chk("tx request", 1, transmit_dma_request);
            slow <= l[0];
            serve <= 1'b1;
            repeat (40) @(posedge clk);
            serve <= 1'b0;
            chk("tx request", 0, transmit_dma_request);
            rd(ctl, {off3, half(1'b1, 3'(4 - l), 2'(l))}, resp_okay);
            chk("tx_push_ready", l != 0, tx_push_ready);
            chk("tx_pop_valid", 1, tx_pop_valid);
            tx_pop <= 1'b1;
            @(negedge clk);
            chk("tx_pop_data", base, tx_pop_data);
            @(posedge clk);
            tx_pop <= 1'b0;
            base = base + 16'(4 - l);
            wr(ctl, {off3, half(1'b0, 3'h0, 2'(l)) | 16'h0010}, resp_okay);
            chk("tx request", 0, transmit_dma_request);
            rd(ctl, {off3, half(1'b0, 3'h0, 2'(l))}, resp_okay);
        end
        $display("tx level test done");
    endtask

    task automatic end_sim;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        #(50 * 20000);
        fails++;
        end_sim;
    end

    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        t_reset;
        t_rx_levels;
        t_rx_drain;
        t_tx_levels;
        end_sim;
    end
endmodule
